// [bit_serial_regs.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef BIT_SERIAL_REGS_VH
`define BIT_SERIAL_REGS_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ADDR_CONTROL 3'h0
`define ADDR_DATA 3'h1
`define ADDR_CONFIG 3'h2
`define ADDR_IRQ_EN_A 3'h3
`define ADDR_IRQ_EN_B 3'h4
`define ADDR_PRIO_LOW 3'h5
`define ADDR_PRIO_HIGH 3'h6
// ----------------------------------------
// Control register, read view
// ----------------------------------------
`define CTL_RX_BIT 7
`define CTL_SERVICE 6
`define CTL_BIT_READY 5
`define CTL_ARB_LOST 4
`define CTL_START 3
`define CTL_STOP 2
`define CTL_MASTER 1
// ----------------------------------------
// Control register, write view
// ----------------------------------------
`define CTL_CLR_TX_ACT 7
`define CTL_IDLE 6
`define CTL_CLR_BIT_READY 5
`define CTL_CLR_ARB 4
`define CTL_CLR_START 3
`define CTL_CLR_STOP 2
`define CTL_SEND_RSTART 1
`define CTL_SEND_STOP 0
// ----------------------------------------
// Data, config, enable and priority fields
// ----------------------------------------
`define DATA_TX_BIT 7
`define CFG_MASTER_REQ 6
`define CFG_TIMER_RUN 5
`define CFG_TIMEOUT 4
`define CFG_PRESCALE_HI 1
`define CFG_PRESCALE_LO 0
`define IRQ_A_GLOBAL 7
`define IRQ_B_SERIAL 0
`define IRQ_B_TIMER 7
`define PRIO_TIMER 7
// ----------------------------------------
// Reset values and timer counts
// ----------------------------------------
`define CONFIG_RESET 8'h00
`define TIMER_MIN_MARK 10'h008
`define TIMER_TOP 10'h3ff
`define MIN_COUNT_SEL0 4'h7
`define MIN_COUNT_SEL1 4'h6
`define MIN_COUNT_SEL2 4'h5
`define MIN_COUNT_SEL3 4'h4
`endif

// [pin_sync.v]
// Two-stage synchroniser for asynchronous pin inputs
module pin_sync #(
    parameter WIDTH = 2
) (
    input wire ref_clk,
    input wire rst_n,
    input wire [WIDTH-1:0] async_in,
    input wire [WIDTH-1:0] reset_val,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_ff <= {WIDTH{1'b1}};
            sync_ff <= {WIDTH{1'b1}};
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end
    assign sync_out = sync_ff;
endmodule

// [bit_serial_if.v]
// Single-bit two-wire serial interface with bus timing counter
// Notes on behaviour
// - Timer low three bits time the minimum SCL, start and stop spans
// - Timer runs on CPU clock; preload chosen by two-bit prescale field
// - Full ten-bit timer measures SCL idle span; each SCL edge reloads it
// - Long-span count runs only inside a frame, after a start
// - Carry comes 1020 to 1023 cycles after the last SCL change
// - Carry resets the interface, releases SCL, raises timer interrupt
// - Timer runs and resets interface only while timer-run bit set
// - Serial enable at bit 0, timer enable at bit 7 of enable reg B
// - Timer interrupt priority from high and low priority bits
// - Serial interrupt when global and serial enables and service flag set
// - Each SCL rising edge samples SDA into received bit
// - Data register reads received bit on top; reading clears bit-ready
// - Service flag is OR of bit-ready, arb-lost, start and stop flags
// - Bit-ready set on SCL rise unless idle slave; software clears it
// - SCL held low after bit-ready until software clears it
// - Low phase still lasts the minimum low time on fast response
// - Each SCL edge preloads timer with 8 minus cycle count
// - SDA driven low by start generation or by a zero transmit bit while transmit-active, set by data or start/stop
// - Transmit bit reaches SDA only while SCL is low
// - SCL stays stretched while any service flag remains set
`include "bit_serial_regs.vh"
module bit_serial_if (
    input wire ref_clk,
    input wire rst_n,
    input wire [2:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [7:0] reg_rdata,
    input wire scl_in,
    output wire scl_out,
    output wire scl_oe,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    output wire serial_irq,
    output wire bus_timer_irq,
    output wire [1:0] bus_timer_prio
);
    // ----------------------------------------
    // State and registers
    // ----------------------------------------
    reg [7:0] rdata_ff;
    reg [7:0] config_ff;
    reg global_irq_enable_ff;
    reg serial_irq_enable_ff;
    reg bus_timer_irq_enable_ff;
    reg bus_timer_prio_low_ff;
    reg bus_timer_prio_high_ff;
    reg received_bit_ff;
    reg bit_ready_flag_ff;
    reg arbitration_lost_flag_ff;
    reg start_seen_flag_ff;
    reg stop_seen_flag_ff;
    reg tx_active_ff;
    reg transmit_bit_ff;
    reg master_ff;
    reg idle_ff;
    reg in_frame_ff;
    reg rstart_pend_ff;
    reg stop_pend_ff;
    reg [9:0] timer_ff;
    reg scl_oe_ff;
    reg sda_oe_ff;
    reg scl_q_ff;
    reg sda_q_ff;
    reg serial_irq_ff;
    reg bus_timer_irq_ff;
    reg line_low_ff;
    wire [1:0] pins_s;
    wire scl_s;
    wire sda_s;
    wire scl_rise;
    wire scl_edge;
    wire start_det;
    wire stop_det;
    wire min_ok;
    wire timer_run;
    wire timeout;
    wire attn;
    wire wr_ctl;
    wire wr_data;
    wire wr_cfg;
    wire rd_data;
    wire not_idle;
    wire arb_loss;
    wire auto_start;
    wire start_go;
    wire stop_go;
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function [9:0] preload;
        input [1:0] sel;
        reg [3:0] cnt;
        begin
            case (sel)
                2'h0: cnt = `MIN_COUNT_SEL0;
                2'h1: cnt = `MIN_COUNT_SEL1;
                2'h2: cnt = `MIN_COUNT_SEL2;
                default: cnt = `MIN_COUNT_SEL3;
            endcase
            preload = `TIMER_MIN_MARK - {6'h00, cnt};
        end
    endfunction
    // ----------------------------------------
    // Pin synchronisation and edge detection
    // ----------------------------------------
    pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({scl_in, sda_in}),
        .reset_val(2'h3),
        .sync_out(pins_s)
    );
    assign scl_s = pins_s[1];
    assign sda_s = pins_s[0];
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_edge = scl_s ^ scl_q_ff;
    assign start_det = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_det = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    // ----------------------------------------
    // Decode and combined terms
    // ----------------------------------------
    assign wr_ctl = reg_wr & (reg_addr == `ADDR_CONTROL);
    assign wr_data = reg_wr & (reg_addr == `ADDR_DATA);
    assign wr_cfg = reg_wr & (reg_addr == `ADDR_CONFIG);
    assign rd_data = reg_rd & (reg_addr == `ADDR_DATA);
    assign attn = bit_ready_flag_ff | arbitration_lost_flag_ff |
        start_seen_flag_ff | stop_seen_flag_ff;
    assign not_idle = ~idle_ff | master_ff;
    assign min_ok = |timer_ff[9:3];
    assign timer_run = config_ff[`CFG_TIMER_RUN];
    assign timeout = timer_run & in_frame_ff &
        (timer_ff == `TIMER_TOP);
    assign arb_loss = tx_active_ff & transmit_bit_ff & scl_rise & ~sda_s;
    assign auto_start = config_ff[`CFG_MASTER_REQ] & ~in_frame_ff &
        ~master_ff & sda_s;
    assign start_go = scl_s & min_ok & ~sda_oe_ff & ~timeout &
        (rstart_pend_ff | auto_start);
    assign stop_go = scl_s & min_ok & stop_pend_ff & ~timeout;
    // ----------------------------------------
    // Bus timing counter
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            timer_ff <= 10'h000;
        else if (!timer_run)
            timer_ff <= 10'h000;
        else if (scl_edge | start_det | stop_det)
            timer_ff <= preload(config_ff[1:0]);
        else if (timeout)
            timer_ff <= preload(config_ff[1:0]);
        else if (in_frame_ff | ~min_ok)
            timer_ff <= timer_ff + 10'h001;
    end
    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            config_ff <= `CONFIG_RESET;
            global_irq_enable_ff <= 1'b0;
            serial_irq_enable_ff <= 1'b0;
            bus_timer_irq_enable_ff <= 1'b0;
            bus_timer_prio_low_ff <= 1'b0;
            bus_timer_prio_high_ff <= 1'b0;
        end
        else
        begin
            if (wr_cfg)
            begin
                config_ff[7:5] <= reg_wdata[7:5];
                config_ff[3:0] <= reg_wdata[3:0];
            end
            if (timeout)
                config_ff[`CFG_TIMEOUT] <= 1'b1;
            else if (wr_cfg & reg_wdata[`CFG_TIMEOUT])
                config_ff[`CFG_TIMEOUT] <= 1'b0;
            if (reg_wr & (reg_addr == `ADDR_IRQ_EN_A))
                global_irq_enable_ff <= reg_wdata[`IRQ_A_GLOBAL];
            if (reg_wr & (reg_addr == `ADDR_IRQ_EN_B))
            begin
                serial_irq_enable_ff <= reg_wdata[`IRQ_B_SERIAL];
                bus_timer_irq_enable_ff <= reg_wdata[`IRQ_B_TIMER];
            end
            if (reg_wr & (reg_addr == `ADDR_PRIO_LOW))
                bus_timer_prio_low_ff <= reg_wdata[`PRIO_TIMER];
            if (reg_wr & (reg_addr == `ADDR_PRIO_HIGH))
                bus_timer_prio_high_ff <= reg_wdata[`PRIO_TIMER];
        end
    end
    // ----------------------------------------
    // Service flags and receive path
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            received_bit_ff <= 1'b0;
            bit_ready_flag_ff <= 1'b0;
            arbitration_lost_flag_ff <= 1'b0;
            start_seen_flag_ff <= 1'b0;
            stop_seen_flag_ff <= 1'b0;
            idle_ff <= 1'b1;
            in_frame_ff <= 1'b0;
        end
        else if (timeout)
        begin
            bit_ready_flag_ff <= 1'b0;
            arbitration_lost_flag_ff <= 1'b0;
            start_seen_flag_ff <= 1'b0;
            stop_seen_flag_ff <= 1'b0;
            idle_ff <= 1'b1;
            in_frame_ff <= 1'b0;
        end
        else
        begin
            if (scl_rise)
                received_bit_ff <= sda_s;
            if (scl_rise & not_idle)
                bit_ready_flag_ff <= 1'b1;
            else if (wr_data | rd_data |
                (wr_ctl & reg_wdata[`CTL_CLR_BIT_READY]))
                bit_ready_flag_ff <= 1'b0;
            if (arb_loss)
                arbitration_lost_flag_ff <= 1'b1;
            else if (wr_ctl & reg_wdata[`CTL_CLR_ARB])
                arbitration_lost_flag_ff <= 1'b0;
            if (start_det & not_idle)
                start_seen_flag_ff <= 1'b1;
            else if (wr_ctl & reg_wdata[`CTL_CLR_START])
                start_seen_flag_ff <= 1'b0;
            if (stop_det & not_idle)
                stop_seen_flag_ff <= 1'b1;
            else if (wr_ctl & reg_wdata[`CTL_CLR_STOP])
                stop_seen_flag_ff <= 1'b0;
            if (start_det)
                idle_ff <= 1'b0;
            else if (wr_ctl & reg_wdata[`CTL_IDLE])
                idle_ff <= 1'b1;
            if (start_det)
                in_frame_ff <= 1'b1;
            else if (stop_det)
                in_frame_ff <= 1'b0;
        end
    end
    // ----------------------------------------
    // Transmit state and master role
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tx_active_ff <= 1'b0;
            transmit_bit_ff <= 1'b1;
            master_ff <= 1'b0;
            rstart_pend_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
        end
        else if (timeout | arb_loss)
        begin
            tx_active_ff <= 1'b0;
            master_ff <= 1'b0;
            rstart_pend_ff <= 1'b0;
            stop_pend_ff <= 1'b0;
        end
        else
        begin
            if (wr_ctl & reg_wdata[`CTL_SEND_RSTART])
            begin
                tx_active_ff <= 1'b1;
                transmit_bit_ff <= 1'b1;
                rstart_pend_ff <= 1'b1;
            end
            else if (wr_ctl & reg_wdata[`CTL_SEND_STOP])
            begin
                tx_active_ff <= 1'b1;
                transmit_bit_ff <= 1'b0;
                stop_pend_ff <= 1'b1;
            end
            else if (wr_data)
            begin
                tx_active_ff <= 1'b1;
                transmit_bit_ff <= reg_wdata[`DATA_TX_BIT];
            end
            else if (rd_data | (wr_ctl & reg_wdata[`CTL_CLR_TX_ACT]))
                tx_active_ff <= 1'b0;
            if (start_go)
                rstart_pend_ff <= 1'b0;
            if (stop_go)
                stop_pend_ff <= 1'b0;
            if (start_go & auto_start & ~rstart_pend_ff)
                master_ff <= 1'b1;
            else if (stop_det)
                master_ff <= 1'b0;
        end
    end
    // ----------------------------------------
    // Line drivers, open drain
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
            scl_oe_ff <= 1'b0;
            sda_oe_ff <= 1'b0;
            line_low_ff <= 1'b0;
        end
        else
        begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
            line_low_ff <= 1'b0;
            if (timeout)
                scl_oe_ff <= 1'b0;
            else if (scl_oe_ff)
                scl_oe_ff <= attn | ~min_ok | scl_s | scl_q_ff;
            else if (~scl_s & ~scl_q_ff & attn)
                scl_oe_ff <= 1'b1;
            else if (master_ff & scl_s & min_ok &
                ~rstart_pend_ff & ~stop_pend_ff)
                scl_oe_ff <= 1'b1;
            if (timeout | arb_loss)
                sda_oe_ff <= 1'b0;
            else if (start_go)
                sda_oe_ff <= 1'b1;
            else if (stop_go)
                sda_oe_ff <= 1'b0;
            else if (~scl_s)
                sda_oe_ff <= tx_active_ff & ~transmit_bit_ff;
        end
    end
    // ----------------------------------------
    // Read data and interrupt requests
    // ----------------------------------------
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata_ff <= 8'h00;
            serial_irq_ff <= 1'b0;
            bus_timer_irq_ff <= 1'b0;
        end
        else
        begin
            serial_irq_ff <= global_irq_enable_ff & serial_irq_enable_ff &
                attn;
            bus_timer_irq_ff <= global_irq_enable_ff &
                bus_timer_irq_enable_ff & config_ff[`CFG_TIMEOUT];
            if (!reg_rd)
                rdata_ff <= 8'h00;
            else
            begin
                case (reg_addr)
                    `ADDR_CONTROL: rdata_ff <= {received_bit_ff, attn,
                        bit_ready_flag_ff, arbitration_lost_flag_ff,
                        start_seen_flag_ff, stop_seen_flag_ff,
                        master_ff, 1'b0};
                    `ADDR_DATA: rdata_ff <= {received_bit_ff, 7'h00};
                    `ADDR_CONFIG: rdata_ff <= config_ff;
                    `ADDR_IRQ_EN_A: rdata_ff <= {global_irq_enable_ff, 7'h00};
                    `ADDR_IRQ_EN_B: rdata_ff <= {bus_timer_irq_enable_ff,
                        6'h00, serial_irq_enable_ff};
                    `ADDR_PRIO_LOW: rdata_ff <= {bus_timer_prio_low_ff, 7'h00};
                    `ADDR_PRIO_HIGH: rdata_ff <= {bus_timer_prio_high_ff, 7'h00};
                    default: rdata_ff <= 8'h00;
                endcase
            end
        end
    end
    assign reg_rdata = rdata_ff;
    assign scl_out = line_low_ff;
    assign sda_out = line_low_ff;
    assign scl_oe = scl_oe_ff;
    assign sda_oe = sda_oe_ff;
    assign serial_irq = serial_irq_ff;
    assign bus_timer_irq = bus_timer_irq_ff;
    assign bus_timer_prio = {bus_timer_prio_high_ff, bus_timer_prio_low_ff};
endmodule

// [bit_serial_sva.sv]
// Port assertions for the single-bit serial interface
`include "bit_serial_regs.vh"
module bit_serial_sva (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic serial_irq,
    input wire logic bus_timer_irq,
    input wire logic [1:0] bus_timer_prio
);
    timeunit 1ns;
    timeprecision 1ps;
    reg glob_ff;
    always @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
            glob_ff <= 1'b0;
        else if (reg_wr && reg_addr == `ADDR_IRQ_EN_A)
            glob_ff <= reg_wdata[`IRQ_A_GLOBAL];
    end
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    sequence data_rd;
        $past(reg_rd) && $past(reg_addr) == `ADDR_DATA;
    endsequence
    sequence ctl_rd;
        $past(reg_rd) && $past(reg_addr) == `ADDR_CONTROL;
    endsequence
    sequence carry_seen;
        $rose(bus_timer_irq) && !$past(reg_wr, 2);
    endsequence
    property prio_track;
        reg_wr && reg_addr == `ADDR_PRIO_LOW
            |-> ##1 bus_timer_prio[0] == $past(reg_wdata[`PRIO_TIMER]);
    endproperty
    chk_data_form: assert property (data_rd |-> reg_rdata[6:0] == 7'h00)
        else $error("data read low bits not zero");
    chk_service_or: assert property (ctl_rd |-> reg_rdata[`CTL_SERVICE] == |reg_rdata[5:2])
        else $error("service flag differs from flag OR");
    chk_open_drain: assert property (!scl_out && !sda_out)
        else $error("line driven high");
    chk_sda_scl_low: assert property ($rose(sda_oe)
        |-> !($past(scl_in, 2) && $past(scl_in, 3) && $past(scl_in, 4)))
        else $error("data line driven while clock high");
    chk_stretch_min: assert property ($rose(scl_oe) |-> scl_oe[*3])
        else $error("clock low phase too short");
    chk_carry_release: assert property (carry_seen |-> ##[0:2] (!scl_oe && !sda_oe))
        else $error("lines not released on timeout");
    chk_prio_track: assert property (prio_track)
        else $error("timer priority not following register");
    chk_irq_masked: assert property (!glob_ff && !$past(glob_ff)
        |-> !serial_irq && !bus_timer_irq)
        else $error("interrupt with global enable off");
endmodule
bind bit_serial_if bit_serial_sva chk (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .scl_in, .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe,
    .serial_irq, .bus_timer_irq, .bus_timer_prio);

// [peer_model.sv]
// Outside bus party that frames and clocks single bits on the two wires
module peer_model (
    input wire logic ref_clk,
    input wire logic scl,
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 12;
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Release clock, wait out any stretching
    task automatic rise(output logic ok);
        int n;
        n = 0;
        scl_low <= 1'b0;
        while (scl !== 1'b1 && n < 2000)
        begin
            @(posedge ref_clk);
            n++;
        end
        ok = n < 2000;
        idle(HALF);
    endtask
    task automatic start_frame();
        sda_low <= 1'b1;
        idle(HALF);
        scl_low <= 1'b1;
        idle(HALF);
    endtask
    task automatic clock_bit(input logic b, output logic ok);
        sda_low <= !b;
        idle(HALF);
        rise(ok);
        scl_low <= 1'b1;
        idle(HALF);
    endtask
    task automatic stop_frame(output logic ok);
        sda_low <= 1'b1;
        idle(HALF);
        rise(ok);
        sda_low <= 1'b0;
        idle(HALF);
    endtask
endmodule

// [tb_top.sv]
// Bench for the single-bit serial interface with a bus peer
`include "bit_serial_regs.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    wire [7:0] reg_rdata;
    wire scl_out, scl_oe, sda_out, sda_oe, serial_irq, bus_timer_irq, scl_low, sda_low;
    wire [1:0] bus_timer_prio;
    wire scl = !(scl_oe || scl_low);
    wire sda = !(sda_oe || sda_low);
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    always #2.5 ref_clk = ~ref_clk;
    bit_serial_if DUT (.ref_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
        .scl_in(scl), .scl_out, .scl_oe, .sda_in(sda), .sda_out, .sda_oe, .serial_irq,
        .bus_timer_irq, .bus_timer_prio);
    peer_model PEER (.ref_clk, .scl, .scl_low, .sda_low);
    // ----
    // Bus tasks
    // ----
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp, what);
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic wait_release();
        int n;
        n = 0;
        while (scl_oe !== 1'b0 && n < 40)
        begin
            @(posedge ref_clk);
            n++;
        end
        check(8'(n < 40), 8'h01, "stretch released");
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_registers();
        wr(3'h7, 8'hff);
        rd_chk(3'h7, 8'h00, "unmapped read");
        rd_chk(`ADDR_CONFIG, `CONFIG_RESET, "config reset");
        wr(`ADDR_IRQ_EN_B, 8'h81);
        rd_chk(`ADDR_IRQ_EN_B, 8'h81, "enable reg b");
        wr(`ADDR_PRIO_LOW, 8'h80);
        wr(`ADDR_PRIO_HIGH, 8'h80);
        wait_cyc(2);
        check(8'(bus_timer_prio), 8'h03, "timer priority");
        wr(`ADDR_CONFIG, 8'h20);
        wait_cyc(1100);
        rd_chk(`ADDR_CONFIG, 8'h20, "no timeout outside frame");
    endtask
    task automatic t_receive();
        logic ok;
        logic [7:0] b;
        wr(`ADDR_IRQ_EN_A, 8'h80);
        PEER.start_frame();
        for (int i = 0; i < 2; i++)
        begin
            b = (i == 0) ? 8'h80 : 8'h00;
            PEER.clock_bit(b[7], ok);
            check(8'(ok), 8'h01, "clock rose");
            check(8'(scl_oe), 8'h01, "clock stretched");
            check(8'(serial_irq), 8'h01, "serial irq");
            wait_cyc(30);
            rd_chk(`ADDR_CONTROL, b | 8'h60, "control after bit");
            check(8'(scl_oe), 8'h01, "still stretched");
            if (i == 0)
                rd_chk(`ADDR_DATA, b, "data read");
            else
                wr(`ADDR_CONTROL, 8'h20);
            wait_release();
            rd_chk(`ADDR_CONTROL, b, "flags clear");
            check(8'(serial_irq), 8'h00, "irq cleared");
        end
    endtask
    task automatic t_transmit();
        logic ok;
        check(8'(sda_oe), 8'h00, "data line free");
        wr(`ADDR_DATA, 8'h00);
        wait_cyc(5);
        check(8'(sda_oe), 8'h01, "data driven low");
        PEER.clock_bit(1'b1, ok);
        check(8'(ok), 8'h01, "clock rose");
        rd_chk(`ADDR_DATA, 8'h00, "own bit seen");
        wait_cyc(5);
        check(8'(sda_oe), 8'h00, "data released");
        wait_release();
    endtask
    task automatic t_stop();
        logic ok;
        PEER.stop_frame(ok);
        check(8'(ok), 8'h01, "clock rose");
        rd_chk(`ADDR_CONTROL, 8'h64, "stop seen");
        wr(`ADDR_CONTROL, 8'h24);
        rd_chk(`ADDR_CONTROL, 8'h00, "stop cleared");
        wr(`ADDR_DATA, 8'h00);
        wait_cyc(5);
        check(8'(sda_oe), 8'h00, "no drive while clock high");
        wr(`ADDR_CONTROL, 8'h80);
    endtask
    task automatic t_timeout();
        PEER.start_frame();
        check(8'(sda_oe), 8'h00, "transmit state cleared");
        wait_cyc(990);
        rd_chk(`ADDR_CONFIG, 8'h20, "no early timeout");
        wait_cyc(40);
        rd_chk(`ADDR_CONFIG, 8'h30, "timeout flag");
        check(8'(bus_timer_irq), 8'h01, "timer irq");
        check(8'(scl_oe), 8'h00, "clock released");
        wr(`ADDR_CONFIG, 8'h30);
        rd_chk(`ADDR_CONFIG, 8'h20, "flag cleared");
        wait_cyc(2);
        check(8'(bus_timer_irq), 8'h00, "timer irq cleared");
    endtask
    task automatic report_and_stop();
        $display("Checks %0d, miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_registers();
        t_receive();
        t_transmit();
        t_stop();
        t_timeout();
        report_and_stop();
    end
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            miscompares++;
            report_and_stop();
        end
    end
endmodule
